// *** include/mrc_pkg.sv ***
// Constants and types shared by the master reception status block.
package mrc_pkg;
    // ----------------------------------------------------------------
    // Register offsets on the APB (byte addresses).
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_FRAME_CTRL = 8'h00; // Frame control register.
    localparam logic [7:0] ADDR_COMMAND = 8'h04; // Command register.
    localparam logic [7:0] ADDR_FLAG = 8'h08; // Flag register.
    localparam logic [7:0] ADDR_RETURN = 8'h0c; // Return code register.
    localparam logic [7:0] ADDR_RX_FIFO = 8'h10; // Receive FIFO, read pops.
    localparam logic [7:0] ADDR_BYTE_CNT = 8'h14; // Master reception byte counter.
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18; // Sticky events, write one to clear.
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c; // Interrupt mask.

    // ----------------------------------------------------------------
    // Field positions and codes.
    // ----------------------------------------------------------------
    localparam int CMD_IRS_BIT = 4; // Interrupt select flag position.
    localparam int CMD_MODE_BIT = 5; // Communication mode position.
    localparam logic [3:0] CMD_MASTER_A = 4'h8; // Master communication request.
    localparam logic [3:0] CMD_MASTER_B = 4'h9; // Master communication request.
    localparam logic [3:0] RC_STARTED = 4'h4; // Master reception started.
    localparam logic [3:0] RC_FULL = 4'h5; // Receive buffer full.
    localparam logic [3:0] RC_DONE = 4'h6; // Normal end.
    localparam logic [3:0] RC_ABORT = 4'h7; // Aborted.
    localparam logic [7:0] RC_RESET = 8'hff; // Return code register after reset.
    localparam logic [8:0] HDR_COUNT = 9'h003; // Header bytes placed in the FIFO.
    localparam logic [8:0] LEN_ZERO_MEANS = 9'h100; // Length field value zero.
    localparam int IRQ_RC_BIT = 0; // Return code change event.
    localparam int IRQ_LOST_BIT = 1; // Byte lost after buffer full.

    // ----------------------------------------------------------------
    // Timing.
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ = 250; // Clock rate in MHz.
    localparam int FULL_READ_US_MODE0 = 1570; // Host read deadline, mode 0, us.
    localparam int FULL_READ_US_MODE1 = 390; // Host read deadline, mode 1, us.
    localparam int FULL_CYC_MODE0 = FULL_READ_US_MODE0 * CLOCK_MHZ; // Rounded down.
    localparam int FULL_CYC_MODE1 = FULL_READ_US_MODE1 * CLOCK_MHZ; // Rounded down.
    localparam int TIMER_W = 19; // Width of the deadline timer.

    // Sequencer states.
    typedef enum logic [2:0] {
        MRC_IDLE = 3'b000,
        MRC_ARB = 3'b001,
        MRC_HDR = 3'b010,
        MRC_DATA = 3'b011,
        MRC_WAIT = 3'b100
    } mrc_state_t;
endpackage : mrc_pkg

// *** design/mrc_rx_fifo.sv ***
// Receive FIFO with registered read data.
`timescale 1ns/1ps
`default_nettype none
module mrc_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 40
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    output logic full,
    output logic empty,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH); // Pointer width.
    localparam int CW = $clog2(DEPTH + 1); // Count width.
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1); // Last slot index.
    localparam logic [CW-1:0] FULLC = CW'(DEPTH); // Count when full.

    logic [WIDTH-1:0] mem [0:DEPTH-1]; // Storage.
    logic [PW-1:0] wr_ptr; // Next slot to write.
    logic [PW-1:0] rd_ptr; // Oldest slot.
    logic do_push; // Push that is accepted.
    logic do_pop; // Pop that is accepted.

    assign full = (count == FULLC);
    assign empty = (count == '0);
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    // Storage writes; no reset needed on the data itself.
    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr] <= wdata;
        end
    end

    // The head word is fetched every cycle so a read sees a register.
    always_ff @(posedge clock) begin
        rdata <= mem[rd_ptr];
    end

    // Pointers and occupancy.
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : mrc_rx_fifo
`default_nettype wire

// *** design/mrc_master_rx.sv ***
// Master reception return code logic with APB registers and receive FIFO.
//
// Functional notes
// - Command 1000 or 1001 requests bus mastership.
// - Code 0100 after win and header.
// - Control field received enables FIFO storage.
// - Address, control, length bytes enter FIFO.
// - Code 0101 when FIFO cannot take byte.
// - Late host read loses byte, NAK sent.
// - Code 0110 when all data received.
// - Normal end clears master request flag.
// - Lost arbitration aborts with 0111.
// - Slave NAK on address/control aborts.
// - Own NAK on length aborts, unicast.
// - Frame ending short aborts with 0111.
// - Every abort clears master request flag.
// - Byte counter loads 3, counts bytes.
// - Return code change raises selected interrupt.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mrc_master_rx
    import mrc_pkg::*;
#(
    parameter int FIFO_DEPTH = 40,
    parameter logic [TIMER_W-1:0] FULL_WAIT_MODE0 = TIMER_W'(FULL_CYC_MODE0),
    parameter logic [TIMER_W-1:0] FULL_WAIT_MODE1 = TIMER_W'(FULL_CYC_MODE1)
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic LINK_WON,
    input wire logic LINK_LOST,
    input wire logic LINK_SLAVE_NAK,
    input wire logic LINK_CTRL_DONE,
    input wire logic LINK_LEN_OK,
    input wire logic LINK_LEN_NAK,
    input wire logic LINK_BROADCAST,
    input wire logic [7:0] LINK_SLAVE_ADDR,
    input wire logic [7:0] LINK_CTRL,
    input wire logic [7:0] LINK_LEN,
    input wire logic LINK_BYTE_VALID,
    input wire logic [7:0] LINK_BYTE,
    input wire logic LINK_FRAME_END,
    output logic MASTER_REQ,
    output logic BYTE_NAK
);
    // ----------------------------------------------------------------
    // Declarations.
    // ----------------------------------------------------------------
    mrc_state_t state; // Sequencer state.
    logic [3:0] frame_ctrl; // Control bits of the next frame.
    logic [5:0] command; // Command code, interrupt select, mode.
    logic [3:0] rc; // Master return code.
    logic rc_evt; // Pulse: return code was written.
    logic lost_evt; // Pulse: a byte was dropped.
    logic [1:0] irq_status; // Sticky interrupt events.
    logic [1:0] irq_mask; // Interrupt enables.
    logic won; // Arbitration won in this frame.
    logic fifo_ready; // FIFO may take bytes of this frame.
    logic [7:0] hdr [0:2]; // Header bytes latched at the length field.
    logic [1:0] hdr_idx; // Next header byte to store.
    logic [8:0] expected; // Data bytes announced by the length field.
    logic [8:0] rcvd; // Data bytes taken so far.
    logic [8:0] byte_cnt; // Master reception byte counter.
    logic [7:0] held; // Byte waiting for room in the FIFO.
    logic [TIMER_W-1:0] timer; // Host read deadline countdown.
    logic push; // FIFO write strobe.
    logic [7:0] push_data; // FIFO write data.
    logic [7:0] fifo_rdata; // FIFO head.
    logic fifo_full; // FIFO full.
    logic access; // APB access cycle before the answer.
    logic wr_done; // APB write completes.
    logic rd_done; // APB read completes.
    logic start_req; // Master reception requested.
    logic rx_ctrl; // Frame control holds a slave-to-master code.
    logic abort; // Abort cause seen this cycle.
    logic data_push; // A data byte is stored.
    logic last; // The final announced byte is stored.
    logic [7:0] next_rcr; // Return code register image.
    logic [31:0] next_rdata; // Read mux.
    logic next_err; // Unmapped address.

    // ----------------------------------------------------------------
    // APB decode.
    // ----------------------------------------------------------------
    // One wait state: the answer comes in the cycle after the first access.
    assign access = PSEL && PENABLE && !PREADY;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    assign rd_done = PSEL && PENABLE && PREADY && !PWRITE && !PSLVERR;
    assign next_rcr = {RC_RESET[7:4], rc};

    // Slave-to-master control codes are 0000, 0011 and 0100 to 0111.
    assign rx_ctrl = (frame_ctrl == 4'h0) || (frame_ctrl == 4'h3) ||
                     (frame_ctrl[3:2] == 2'b01);
    assign start_req = wr_done && (PADDR == ADDR_COMMAND) && rx_ctrl &&
                       ((PWDATA[3:0] == CMD_MASTER_A) ||
                        (PWDATA[3:0] == CMD_MASTER_B));

    // Read mux and error decode.
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        unique case (PADDR)
            ADDR_FRAME_CTRL: next_rdata[3:0] = frame_ctrl;
            ADDR_COMMAND: next_rdata[5:0] = command;
            ADDR_FLAG: next_rdata[0] = MASTER_REQ;
            ADDR_RETURN: next_rdata[7:0] = next_rcr;
            ADDR_RX_FIFO: next_rdata[7:0] = fifo_rdata;
            ADDR_BYTE_CNT: next_rdata[8:0] = byte_cnt;
            ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
            ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
            default: next_err = 1'b1;
        endcase
    end

    // Bus answer registers.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= access;
            PSLVERR <= access && next_err;
            if (access && !PWRITE) begin
                PRDATA <= next_rdata;
            end
        end
    end

    // Software written control registers.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            frame_ctrl <= 4'h0;
            command <= 6'h00;
            irq_mask <= 2'b00;
        end else if (wr_done) begin
            if (PADDR == ADDR_FRAME_CTRL) begin
                frame_ctrl <= PWDATA[3:0];
            end
            if (PADDR == ADDR_COMMAND) begin
                command <= PWDATA[5:0];
            end
            if (PADDR == ADDR_IRQ_MASK) begin
                irq_mask <= PWDATA[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts.
    // ----------------------------------------------------------------
    // Sticky events; a new event in the clearing cycle wins.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            irq_status <= 2'b00;
            IRQ <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_done && (PADDR == ADDR_IRQ_STATUS) && PWDATA[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
            if (rc_evt && command[CMD_IRS_BIT]) begin
                irq_status[IRQ_RC_BIT] <= 1'b1;
            end
            if (lost_evt) begin
                irq_status[IRQ_LOST_BIT] <= 1'b1;
            end
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // Receive FIFO feed.
    // ----------------------------------------------------------------
    // Header bytes, live data bytes or the held byte, in that order.
    always_comb begin
        push = 1'b0;
        push_data = 8'h00;
        if (state == MRC_HDR) begin
            push = fifo_ready && !fifo_full;
            push_data = hdr[hdr_idx];
        end else if (state == MRC_DATA) begin
            push = LINK_BYTE_VALID && fifo_ready && !fifo_full;
            push_data = LINK_BYTE;
        end else if (state == MRC_WAIT) begin
            push = !fifo_full;
            push_data = held;
        end
    end

    assign data_push = push && (state != MRC_HDR);
    assign last = data_push && ((rcvd + 9'h001) == expected);

    // Abort causes by phase.
    assign abort = ((state == MRC_ARB) &&
                    (LINK_LOST || LINK_SLAVE_NAK ||
                     (LINK_LEN_NAK && !LINK_BROADCAST))) ||
                   ((state != MRC_IDLE) && (state != MRC_ARB) &&
                    (LINK_LOST || LINK_FRAME_END));

    mrc_rx_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(CLOCK),
        .reset(RESET),
        .push(push),
        .wdata(push_data),
        .pop(rd_done && (PADDR == ADDR_RX_FIFO)),
        .rdata(fifo_rdata),
        .full(fifo_full),
        .empty(),
        .count()
    );

    // FIFO acceptance opens at the control field of our own frame.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            fifo_ready <= 1'b0;
        end else if (start_req && state == MRC_IDLE) begin
            fifo_ready <= 1'b0;
        end else if (LINK_CTRL_DONE && state == MRC_ARB) begin
            fifo_ready <= 1'b1;
        end
    end

    // Byte counter and data count; left as is at the end of a frame.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            byte_cnt <= 9'h000;
            rcvd <= 9'h000;
        end else if (state == MRC_ARB && LINK_LEN_OK && !abort) begin
            byte_cnt <= HDR_COUNT;
            rcvd <= 9'h000;
        end else if (data_push) begin
            byte_cnt <= byte_cnt + 9'h001;
            rcvd <= rcvd + 9'h001;
        end
    end

    // Header and length latch.
    always_ff @(posedge CLOCK) begin
        if (state == MRC_ARB && LINK_LEN_OK) begin
            hdr[0] <= LINK_SLAVE_ADDR;
            hdr[1] <= LINK_CTRL;
            hdr[2] <= LINK_LEN;
            expected <= (LINK_LEN == 8'h00) ? LEN_ZERO_MEANS : {1'b0, LINK_LEN};
        end
    end

    // ----------------------------------------------------------------
    // Sequencer and return code.
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        rc_evt <= 1'b0;
        lost_evt <= 1'b0;
        BYTE_NAK <= 1'b0;
        if (RESET) begin
            state <= MRC_IDLE;
            rc <= RC_RESET[3:0];
            MASTER_REQ <= 1'b0;
            won <= 1'b0;
            hdr_idx <= 2'd0;
            held <= 8'h00;
            timer <= '0;
        end else if (abort) begin
            // Any abort ends the request and leaves the FIFO alone.
            state <= MRC_IDLE;
            rc <= RC_ABORT;
            rc_evt <= 1'b1;
            MASTER_REQ <= 1'b0;
        end else begin
            unique case (state)
                MRC_IDLE: begin
                    if (start_req) begin
                        state <= MRC_ARB;
                        MASTER_REQ <= 1'b1;
                        won <= 1'b0;
                    end
                end
                MRC_ARB: begin
                    if (LINK_WON) begin
                        won <= 1'b1;
                    end
                    if (LINK_LEN_OK && (won || LINK_WON)) begin
                        state <= MRC_HDR;
                        hdr_idx <= 2'd0;
                        rc <= RC_STARTED;
                        rc_evt <= 1'b1;
                    end
                end
                MRC_HDR: begin
                    hdr_idx <= hdr_idx + 2'd1;
                    if (hdr_idx == 2'd2) begin
                        state <= MRC_DATA;
                    end
                end
                MRC_DATA: begin
                    if (last) begin
                        state <= MRC_IDLE;
                        rc <= RC_DONE;
                        rc_evt <= 1'b1;
                        MASTER_REQ <= 1'b0;
                    end else if (LINK_BYTE_VALID && !push) begin
                        state <= MRC_WAIT;
                        held <= LINK_BYTE;
                        rc <= RC_FULL;
                        rc_evt <= 1'b1;
                        timer <= command[CMD_MODE_BIT] ? FULL_WAIT_MODE1
                                                      : FULL_WAIT_MODE0;
                    end
                end
                MRC_WAIT: begin
                    if (last) begin
                        state <= MRC_IDLE;
                        rc <= RC_DONE;
                        rc_evt <= 1'b1;
                        MASTER_REQ <= 1'b0;
                    end else if (push) begin
                        state <= MRC_DATA;
                    end else if (timer == '0) begin
                        state <= MRC_DATA;
                        BYTE_NAK <= 1'b1;
                        lost_evt <= 1'b1;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                default: state <= MRC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_start_code: assert property (
        (state == MRC_ARB) && LINK_LEN_OK && won && !abort
        |=> (rc == RC_STARTED) && (byte_cnt == HDR_COUNT) && (state == MRC_HDR))
        else $error("start code or counter wrong");
    a_header_three: assert property (
        $rose(state == MRC_HDR) |-> (state == MRC_HDR) [*3] ##1 (state != MRC_HDR))
        else $error("header phase not three cycles");
    a_full_code: assert property (
        (state == MRC_DATA) && LINK_BYTE_VALID && !push && !last && !abort
        |=> (rc == RC_FULL) && (state == MRC_WAIT))
        else $error("buffer full code missing");
    a_late_nak: assert property (
        (state == MRC_WAIT) && (timer == '0) && fifo_full && !abort
        |=> BYTE_NAK ##1 !BYTE_NAK)
        else $error("no NAK after read deadline");
    a_done_flag: assert property (
        last && !abort |=> (rc == RC_DONE) && !MASTER_REQ && rc_evt)
        else $error("normal end not reported");
    a_abort_lost: assert property (
        (state == MRC_ARB) && LINK_LOST |=> (rc == RC_ABORT) && !MASTER_REQ)
        else $error("lost arbitration not aborted");
    a_abort_nak: assert property (
        (state == MRC_ARB) && LINK_SLAVE_NAK |=> (rc == RC_ABORT))
        else $error("slave NAK not aborted");
    a_len_nak: assert property (
        (state == MRC_ARB) && LINK_LEN_NAK && !LINK_BROADCAST |=> (rc == RC_ABORT))
        else $error("length NAK not aborted");
    a_short_frame: assert property (
        ((state == MRC_DATA) || (state == MRC_WAIT)) && LINK_FRAME_END && !last
        |=> (rc == RC_ABORT) && (state == MRC_IDLE) && !MASTER_REQ)
        else $error("short frame not aborted");
    a_count_step: assert property (
        data_push && !abort |=> byte_cnt == $past(byte_cnt) + 9'h001)
        else $error("byte counter did not step");
    a_request_set: assert property (
        start_req && (state == MRC_IDLE) |=> MASTER_REQ && (state == MRC_ARB))
        else $error("request not taken");
    a_rc_irq: assert property (
        rc_evt && command[CMD_IRS_BIT] |=> irq_status[IRQ_RC_BIT] ##1 IRQ || !irq_mask[0])
        else $error("return code change raised no interrupt");

    c_normal_end: cover property ((state == MRC_DATA) ##1 (rc == RC_DONE));
    c_full_then_read: cover property ((state == MRC_WAIT) ##1 (state == MRC_DATA) && !BYTE_NAK);
    c_lost_byte: cover property (BYTE_NAK);
    c_abort: cover property (rc_evt && (rc == RC_ABORT));
endmodule : mrc_master_rx
`default_nettype wire

// *** test/mrc_link_model.sv ***
// Link-side partner: arbitration, header fields and data bytes.
`timescale 1ns/1ps
`default_nettype none
module mrc_link_model (
    input wire logic clk,
    output logic won,
    output logic lost,
    output logic snak,
    output logic ctrl,
    output logic len_ok,
    output logic lnak,
    output logic bv,
    output logic fend,
    output logic [7:0] sa,
    output logic [7:0] cb,
    output logic [7:0] ln,
    output logic [7:0] dat
);
    // Strobes rest low; released fields show the inverse of their last value.
    initial {won, lost, snak, ctrl, len_ok, lnak, bv, fend, sa, cb, ln, dat} = {8'h0, 32'hffffffff};
    // Frame header; how: 0 normal, 1 lost arbitration, 2 slave refusal, 3 own length NAK.
    task automatic head(input logic [7:0] n, input logic [1:0] how);
        @(posedge clk) {won, lost} <= {how != 2'd1, how == 2'd1};
        @(posedge clk) {won, lost, snak} <= {2'b00, how == 2'd2};
        @(posedge clk) {snak, ctrl} <= {1'b0, how[0] == how[1]};
        @(posedge clk) {ctrl, len_ok, lnak, sa, cb, ln} <=
            {1'b0, how == 2'd0, how == 2'd3, 8'h2a, 8'h03, n};
        @(posedge clk) {len_ok, lnak, sa, cb, ln} <= {2'b00, ~sa, ~cb, ~ln};
        repeat (4) @(posedge clk);
    endtask : head
    // Data bytes with idle gaps between them, then the end of the frame.
    task automatic body(input int sent, input int gap);
        for (int i = 0; i < sent; i++) begin
            @(posedge clk) {bv, dat} <= {1'b1, 8'h40 + 8'(i)};
            @(posedge clk) {bv, dat} <= {1'b0, ~dat};
            repeat (gap) @(posedge clk);
        end
        @(posedge clk) fend <= 1'b1;
        @(posedge clk) fend <= 1'b0;
    endtask : body
endmodule : mrc_link_model
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the master reception status block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mrc_pkg::*;
    logic CLOCK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err;
    logic [7:0] PADDR = 8'h00, LINK_SLAVE_ADDR, LINK_CTRL, LINK_LEN, LINK_BYTE;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, IRQ, MASTER_REQ, BYTE_NAK, LINK_WON, LINK_LOST, LINK_SLAVE_NAK;
    logic LINK_CTRL_DONE, LINK_LEN_OK, LINK_BYTE_VALID, LINK_FRAME_END, LINK_LEN_NAK;
    logic LINK_BROADCAST = 1'b0;
    int bad_count = 0, samples_checked = 0, cyc = 0, nak_seen = 0;
    always #2 CLOCK = ~CLOCK;
    mrc_master_rx #(.FIFO_DEPTH(4), .FULL_WAIT_MODE0(19'd20), .FULL_WAIT_MODE1(19'd4)) uut (
        .CLOCK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .IRQ, .LINK_WON, .LINK_LOST, .LINK_SLAVE_NAK, .LINK_CTRL_DONE,
        .LINK_LEN_OK, .LINK_LEN_NAK, .LINK_BROADCAST, .LINK_SLAVE_ADDR, .LINK_CTRL,
        .LINK_LEN, .LINK_BYTE_VALID, .LINK_BYTE, .LINK_FRAME_END, .MASTER_REQ, .BYTE_NAK);
    mrc_link_model m (.clk(CLOCK), .won(LINK_WON), .lost(LINK_LOST), .snak(LINK_SLAVE_NAK),
        .ctrl(LINK_CTRL_DONE), .len_ok(LINK_LEN_OK), .lnak(LINK_LEN_NAK), .bv(LINK_BYTE_VALID),
        .fend(LINK_FRAME_END), .sa(LINK_SLAVE_ADDR), .cb(LINK_CTRL), .ln(LINK_LEN),
        .dat(LINK_BYTE));
    // Hang limit, and a tally of refused bytes.
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (BYTE_NAK === 1'b1) nak_seen <= nak_seen + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until PREADY is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK) {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge CLOCK) PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        {rd, err} = {PRDATA, PSLVERR};
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk
    // Prepares a reception and requests the bus, interrupt select set, mode in code bit 4.
    task automatic start(input logic [4:0] code);
        apb(1'b1, ADDR_FRAME_CTRL, 32'h3);
        apb(1'b1, ADDR_COMMAND, {26'h0, code[4], 1'b1, code[3:0]});
        rdchk(ADDR_FLAG, 32'h1);
        chk(32'(MASTER_REQ), 32'h1);
    endtask : start
    // Normal reception of one byte, interrupt raised and cleared.
    task automatic t_normal;
        apb(1'b1, ADDR_IRQ_MASK, 32'h3);
        start(CMD_MASTER_A);
        m.head(8'h01, 2'd0);
        rdchk(ADDR_RETURN, 32'hf4);
        rdchk(ADDR_BYTE_CNT, 32'h3);
        m.body(1, 1);
        rdchk(ADDR_RETURN, 32'hf6);
        rdchk(ADDR_FLAG, 32'h0);
        rdchk(ADDR_BYTE_CNT, 32'h4);
        chk(32'(IRQ), 32'h1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge CLOCK);
        chk(32'(IRQ), 32'h0);
        for (int i = 0; i < 4; i++) begin
            rdchk(ADDR_RX_FIFO, 32'(i == 0 ? 8'h2a : i == 1 ? 8'h03 : 8'h01 << 6 * (i - 2)));
        end
    endtask : t_normal
    // Lost arbitration, slave refusal and own length NAK, with the interrupt masked.
    task automatic t_abort;
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        for (int k = 1; k < 4; k++) begin
            start(CMD_MASTER_B);
            m.head(8'h01, 2'(k));
            rdchk(ADDR_RETURN, 32'hf7);
            rdchk(ADDR_FLAG, 32'h0);
            chk(32'(MASTER_REQ), 32'h0);
        end
        chk(32'(IRQ), 32'h0);
    endtask : t_abort
    // Full buffer: mode 0 reads within its deadline, mode 1 misses it and the byte is lost.
    task automatic t_full(input logic m1);
        start({m1, CMD_MASTER_A});
        m.head(8'h02, 2'd0);
        fork
            m.body(2, 30);
            begin
                repeat (36) @(posedge CLOCK);
                rdchk(ADDR_RETURN, 32'hf5);
                rdchk(ADDR_RX_FIFO, 32'h2a);
            end
        join
        chk(32'(nak_seen), 32'(m1));
        rdchk(ADDR_RETURN, m1 ? 32'hf7 : 32'hf6);
        rdchk(ADDR_BYTE_CNT, m1 ? 32'h4 : 32'h5);
        for (int i = 0; i < (m1 ? 3 : 4); i++) begin
            rdchk(ADDR_RX_FIFO, 32'(i == 0 ? 8'h03 : i == 1 ? 8'h02 : 8'h3e + 8'(i)));
        end
    endtask : t_full
    initial begin
        repeat (16) @(posedge CLOCK);
        RESET <= 1'b0;
        rdchk(ADDR_RETURN, 32'hff);
        apb(1'b1, 8'h20, 32'h1);
        chk(32'(err), 32'h1);
        t_normal();
        t_abort();
        t_full(1'b0);
        t_full(1'b1);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
